// file: psfm_top.sv
// Enable sequencing, keep-alive, software enable and fault monitoring.
// Assumes comparator and pin inputs are asynchronous; the serial port,
// pushbutton and slew logic sit on core_clk_in and give one-cycle strobes.
//
// Behaviour
// - A rail enables only after its enable pin held high 200 us.
// - With wait selected, a rail enables only once discharged below 300 mV.
// - Keep-alive bit keeps its rail (rails 1, 2, 3 and 5 only) on regardless of power request or wake.
// - Keep-alive holds until bit cleared, hard reset, or fault.
// - Status and interrupt keep updating for kept-alive rails in standby.
// - Software mode bit 7 makes rails ignore pins, using register bits.
// - Software-enabled rails stay on; mode and enables may share one write.
// - Power request falling clears the enable control register to 0x00.
// - Warn on supply below 2.9 V or die temperature near shutdown.
// - Fault on supply below 2.6 V, rail low 14 ms, or overtemperature.
// - Reset output low until always-alive rail good and 1 s timer done.
// - Reset low on 25 us always-alive loss or hard reset; release 14 ms.
// - Supply low at end of start-up sets undervoltage bit and interrupt.
// - Rail low indication acts only after persisting 25 us.
// - Power-good status has one rail per bit, one meaning good.
// - Power-good low with no rail on; high 250 us after last good.
// - A low rail keeps pin and bit low for the low time plus 250 us.
// - Power-good pin low over 14 ms is a fault unless masked.
// - Slewing pulls the pin low unless ignored; status unaffected.
// - Supply lockout holds rails off and starts hard shutdown when running.
// - Undervoltage warning sets interrupt bit 4 and drives interrupt low.
// - Temperature warning sets bit 6; temperature fault starts shutdown.
// - Supply and thermal monitors are off while every rail is off.
// - Fault reset pulls wake low, restores registers, ignores pins 1 s.
// - Fault shutdown keeps interrupt output and status registers.
`timescale 1ns/10ps
module psfm_top
   import psfm_pkg::*;
#(
   parameter int EN_DELAY = EN_DELAY_CYC,
   parameter int SETTLE = PG_SETTLE_CYC,
   parameter int LONG_LOW = LONG_LOW_CYC,
   parameter int TIMER = TIMER_CYC
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Pins and comparators
   input wire logic [NUM_RAILS-1:0] rail_enable_pin_in,
   input wire logic [NUM_RAILS-1:0] rail_good_in,
   input wire logic [NUM_RAILS-1:0] rail_discharged_in,
   input wire logic power_on_request_in,
   input wire logic supply_warn_in,
   input wire logic supply_fault_in,
   input wire logic supply_lockout_in,
   input wire logic temp_warn_in,
   input wire logic temp_fault_in,
   // Neighbouring logic on the same clock
   input wire logic [NUM_RAILS-1:0] rail_slewing_in,
   input wire logic hard_reset_in,
   // Register writes
   input wire logic enable_control_wr_in,
   input wire logic system_control_two_wr_in,
   input wire logic target_wr_in,
   input wire logic [2:0] target_sel_in,
   input wire logic [7:0] wdata_in,
   input wire logic clear_irq_in,
   // Regulator enables and pins
   output logic [NUM_RAILS-1:0] rail_enable_out,
   output logic power_good_pin_out,
   output logic reset_output_n_out,
   output logic interrupt_n_out,
   output logic wake_pull_low_out,
   // Register read values
   output logic [7:0] regulator_enable_control_out,
   output logic [7:0] system_control_two_out,
   output logic [7:0] power_good_status_out,
   output logic [7:0] interrupt_status_out
);

   localparam int SW = $clog2(TIMER + 1);
   localparam logic [SW-1:0] TIMER_LAST = SW'(TIMER - 1);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   psfm_state_e st_q;
   psfm_state_e st_d;
   logic [SW-1:0] sec_q;
   logic [SW-1:0] sec_d;
   logic [7:0] en_ctrl_q;
   logic [7:0] en_ctrl_d;
   logic [7:0] system_control_two_q;
   logic [7:0] system_control_two_d;
   logic [7:0] keep_q;
   logic [7:0] keep_d;
   logic [7:0] ignore_q;
   logic [7:0] ignore_d;
   logic [7:0] rail_en_q;
   logic [7:0] rail_en_d;
   logic [7:0] power_good_status_q;
   logic [7:0] irq_q;
   logic [7:0] irq_d;
   logic power_good_pin_q;
   logic power_good_pin_d;
   logic por_prev_q;
   logic pb_cause_q;
   logic aa_seen_q;
   logic had_loss_q;
   logic had_loss_d;
   logic rst_n_q;
   logic rst_n_d;
   logic wake_low_q;
   logic irq_n_q;

   logic [7:0] pin_s;
   logic [7:0] good_s;
   logic [7:0] dis_s;
   logic [5:0] misc_s;
   logic por_s;
   logic warn_s;
   logic uvf_s;
   logic lock_s;
   logic twarn_s;
   logic tfault_s;

   logic [7:0] pin_dly;
   logic [7:0] low_f;
   logic [7:0] settled;
   logic [7:0] sel_en;
   logic [7:0] req;
   logic [7:0] tgt_hit;
   logic [7:0] irq_set;
   logic [7:0] irq_hold;
   logic [7:0] irq_clr;
   logic sec_done;
   logic sw_mode;
   logic running;
   logic monitor;
   logic uv_warn;
   logic uv_fault;
   logic t_warn;
   logic t_fault;
   logic pg_low_long;
   logic pgto_fault;
   logic fault_evt;
   logic enter_inhibit;
   logic leave_inhibit;
   logic por_fall;
   logic reg_clear;
   logic pb_hold;
   logic rel_done;
   logic any_en;
   logic all_good;
   logic slew_blk;
   logic startup_uv;

   // One-hot rail select for target register writes.
   function automatic logic [7:0] rail_onehot(input logic [2:0] sel);
      rail_onehot = 8'h01 << sel;
   endfunction

   // -------------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------------
   psfm_sync #(.W(24), .RST(24'h000000)) u_sync_rail (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .d_in({rail_enable_pin_in, rail_good_in, rail_discharged_in}),
      .q_out({pin_s, good_s, dis_s})
   );

   psfm_sync #(.W(6), .RST(6'h00)) u_sync_misc (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .d_in({power_on_request_in, supply_warn_in, supply_fault_in,
             supply_lockout_in, temp_warn_in, temp_fault_in}),
      .q_out(misc_s)
   );

   assign {por_s, warn_s, uvf_s, lock_s, twarn_s, tfault_s} = misc_s;

   // -------------------------------------------------------------------
   // Per-rail timers and enable selection
   // -------------------------------------------------------------------
   assign sw_mode = en_ctrl_q[ENCTL_SW_MODE_BIT];
   assign running = (st_q == PSFM_RUN);

   generate
      for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
         // Rail low only counts after a 25 us persistence.
         psfm_persist #(.COUNT(PG_FILTER_CYC)) u_low (
            .core_clk_in(core_clk_in),
            .reset_n_in(reset_n_in),
            .cond_in(!good_s[i]),
            .done_out(low_f[i])
         );
         // Good must hold 250 us on an enabled rail before it reports.
         psfm_persist #(.COUNT(SETTLE)) u_settle (
            .core_clk_in(core_clk_in),
            .reset_n_in(reset_n_in),
            .cond_in(rail_en_q[i] & !low_f[i] & (good_s[i] | power_good_status_q[i])),
            .done_out(settled[i])
         );
         if (i == 0) begin : g_aa
            assign pin_dly[i] = 1'b1;
            assign sel_en[i] = 1'b1;
            assign req[i] = 1'b1;
         end else begin : g_reg
            psfm_persist #(.COUNT(EN_DELAY)) u_en (
               .core_clk_in(core_clk_in),
               .reset_n_in(reset_n_in),
               .cond_in(pin_s[i]),
               .done_out(pin_dly[i])
            );
            // Software mode disconnects the pin entirely.
            assign sel_en[i] = sw_mode ? en_ctrl_q[i-1] : pin_dly[i];
            // Keep-alive is independent of power request and wake.
            assign req[i] = running & !lock_s
                            & (sel_en[i] | keep_q[i]);
         end
      end
   endgenerate

   // A new enable waits for discharge only when the wait bit is set.
   assign rail_en_d = req & (rail_en_q | dis_s
                             | {8{!system_control_two_q[SYSTEM_CONTROL_TWO_WAIT_BIT]}});

   // -------------------------------------------------------------------
   // Power-good pin and status
   // -------------------------------------------------------------------
   assign any_en = |rail_en_q[7:1];
   assign all_good = &(power_good_status_q | ~rail_en_q);
   assign slew_blk = |(rail_slewing_in & ~ignore_q & rail_en_q);
   // Pin is low with no rail on, or while any enabled rail is not good.
   assign power_good_pin_d = any_en & all_good & !slew_blk;

   psfm_persist #(.COUNT(LONG_LOW)) u_pg_to (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .cond_in(monitor & !power_good_pin_q),
      .done_out(pg_low_long)
   );

   // -------------------------------------------------------------------
   // Warnings and faults
   // -------------------------------------------------------------------
   // Monitors sleep when every rail is off to save standby current.
   assign monitor = any_en;
   assign uv_warn = monitor & warn_s;
   assign t_warn = monitor & twarn_s;
   assign uv_fault = monitor & (uvf_s | lock_s);
   assign t_fault = monitor & tfault_s;
   assign pgto_fault = pg_low_long & !system_control_two_q[SYSTEM_CONTROL_TWO_PG_MASK_BIT];
   assign fault_evt = uv_fault | t_fault | pgto_fault;
   assign sec_done = (sec_q == TIMER_LAST);
   assign startup_uv = (st_q == PSFM_STARTUP) & sec_done & warn_s;

   // -------------------------------------------------------------------
   // Sequencer: start-up timer, run, one-second inhibit
   // -------------------------------------------------------------------
   // Keep-alive rails also drop here, as fault and hard reset demand.
   assign enter_inhibit = running & (fault_evt | hard_reset_in);
   assign leave_inhibit = (st_q == PSFM_INHIBIT) & sec_done
                          & !lock_s & !tfault_s;

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         PSFM_STARTUP: begin
            if (sec_done) begin
               st_d = PSFM_RUN;
            end
         end
         PSFM_RUN: begin
            if (enter_inhibit) begin
               st_d = PSFM_INHIBIT;
            end
         end
         PSFM_INHIBIT: begin
            if (leave_inhibit) begin
               st_d = PSFM_RUN;
            end
         end
         default: begin
            st_d = PSFM_STARTUP;
         end
      endcase
   end

   // One counter serves both one-second intervals.
   assign sec_d = (st_d != st_q || st_d == PSFM_RUN) ? '0 :
                  (sec_done ? sec_q : sec_q + 1'b1);

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q <= PSFM_STARTUP;
         sec_q <= '0;
      end else begin
         st_q <= st_d;
         sec_q <= sec_d;
      end
   end

   // -------------------------------------------------------------------
   // Command registers
   // -------------------------------------------------------------------
   assign por_fall = por_prev_q & !por_s;
   assign reg_clear = enter_inhibit;
   assign tgt_hit = target_wr_in ? rail_onehot(target_sel_in) : 8'h00;

   // Hardware clears win over a write in the same cycle, so a shutdown
   // can never be undone by a late software write.
   assign en_ctrl_d = (reg_clear | por_fall) ? ENCTL_RESET :
                      enable_control_wr_in ? wdata_in : en_ctrl_q;
   assign system_control_two_d = reg_clear ? SYSTEM_CONTROL_TWO_RESET :
                   system_control_two_wr_in ? wdata_in : system_control_two_q;
   assign keep_d = reg_clear ? TGT_FLAGS_RESET :
                   ((keep_q & ~tgt_hit)
                    | (tgt_hit & KEEP_ALIVE_RAILS
                       & {8{wdata_in[TGT_KEEP_ALIVE_BIT]}}));
   assign ignore_d = reg_clear ? TGT_FLAGS_RESET :
                     ((ignore_q & ~tgt_hit)
                      | (tgt_hit & {8{wdata_in[TGT_PG_IGNORE_BIT]}}));

   // Mode and enable bits land in one write.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         en_ctrl_q <= ENCTL_RESET;
         system_control_two_q <= SYSTEM_CONTROL_TWO_RESET;
         keep_q <= TGT_FLAGS_RESET;
         ignore_q <= TGT_FLAGS_RESET;
         por_prev_q <= 1'b0;
      end else begin
         en_ctrl_q <= en_ctrl_d;
         system_control_two_q <= system_control_two_d;
         keep_q <= keep_d;
         ignore_q <= ignore_d;
         por_prev_q <= por_s;
      end
   end

   // -------------------------------------------------------------------
   // Interrupt status
   // -------------------------------------------------------------------
   assign irq_set[2:0] = 3'h0;
   assign irq_set[IRQ_PG_TIMEOUT_BIT] = pgto_fault;
   assign irq_set[IRQ_UV_WARN_BIT] = uv_warn | startup_uv;
   assign irq_set[IRQ_UV_FAULT_BIT] = uv_fault;
   assign irq_set[IRQ_TEMP_WARN_BIT] = t_warn;
   assign irq_set[IRQ_TEMP_FAULT_BIT] = t_fault;
   // Fault bits survive a clear until the inhibit time has passed.
   assign irq_hold = irq_set
                     | ({8{st_q == PSFM_INHIBIT}} & IRQ_FAULT_BITS);
   assign irq_clr = clear_irq_in ? ~irq_hold : 8'h00;
   // Set wins over clear; shutdown does not touch these bits.
   assign irq_d = irq_set | (irq_q & ~irq_clr);

   // -------------------------------------------------------------------
   // Reset output
   // -------------------------------------------------------------------
   assign pb_hold = (st_q == PSFM_INHIBIT) & pb_cause_q;

   psfm_persist #(.COUNT(LONG_LOW)) u_rel (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .cond_in(!low_f[0] & !pb_hold),
      .done_out(rel_done)
   );

   assign had_loss_d = (st_q != PSFM_STARTUP) & (low_f[0] | pb_hold)
                       | (had_loss_q & !rel_done);
   // The first release needs no 14 ms wait, only the start-up timer and a good always-alive rail.
   assign rst_n_d = (st_q != PSFM_STARTUP) & aa_seen_q & !low_f[0]
                    & !pb_hold & (!had_loss_q | rel_done);

   // -------------------------------------------------------------------
   // Status and pin flops
   // -------------------------------------------------------------------
   // Status and pins run in every state, standby included.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rail_en_q <= 8'h00;
         power_good_status_q <= 8'h00;
         power_good_pin_q <= 1'b0;
         irq_q <= IRQ_RESET;
         pb_cause_q <= 1'b0;
         aa_seen_q <= 1'b0;
         had_loss_q <= 1'b0;
         rst_n_q <= 1'b0;
         wake_low_q <= 1'b0;
         irq_n_q <= 1'b1;
      end else begin
         rail_en_q <= rail_en_d;
         power_good_status_q <= settled;
         power_good_pin_q <= power_good_pin_d;
         irq_q <= irq_d;
         if (enter_inhibit) begin
            pb_cause_q <= hard_reset_in;
         end
         aa_seen_q <= aa_seen_q | good_s[0];
         had_loss_q <= had_loss_d;
         rst_n_q <= rst_n_d;
         wake_low_q <= (st_d == PSFM_INHIBIT);
         irq_n_q <= ~|irq_d;
      end
   end

   assign rail_enable_out = rail_en_q;
   assign power_good_pin_out = power_good_pin_q;
   assign reset_output_n_out = rst_n_q;
   assign interrupt_n_out = irq_n_q;
   assign wake_pull_low_out = wake_low_q;
   assign regulator_enable_control_out = en_ctrl_q;
   assign system_control_two_out = system_control_two_q;
   assign power_good_status_out = power_good_status_q;
   assign interrupt_status_out = irq_q;

endmodule // psfm_top

// file: psfm_pkg.sv
// Constants shared by the power sequence and fault monitor block.
// Assumes a single free-running 100 MHz core clock.
package psfm_pkg;

   // -------------------------------------------------------------------
   // Clock and timing figures
   // -------------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int T_EN_DELAY_US = 200;
   localparam int T_PG_FILTER_US = 25;
   localparam int T_PG_SETTLE_US = 250;
   localparam int T_LONG_LOW_MS = 14;
   localparam int T_TIMER_S = 1;
   localparam int EN_DELAY_CYC = T_EN_DELAY_US * CLK_MHZ;
   localparam int PG_FILTER_CYC = T_PG_FILTER_US * CLK_MHZ;
   localparam int PG_SETTLE_CYC = T_PG_SETTLE_US * CLK_MHZ;
   localparam int LONG_LOW_CYC = T_LONG_LOW_MS * 1000 * CLK_MHZ;
   localparam int TIMER_CYC = T_TIMER_S * 1000000 * CLK_MHZ;

   // -------------------------------------------------------------------
   // Rails and register fields
   // -------------------------------------------------------------------
   localparam int NUM_RAILS = 8;
   localparam int ENCTL_SW_MODE_BIT = 7;
   localparam int SYSTEM_CONTROL_TWO_WAIT_BIT = 0;
   localparam int SYSTEM_CONTROL_TWO_PG_MASK_BIT = 7;
   localparam int TGT_PG_IGNORE_BIT = 5;
   localparam int TGT_KEEP_ALIVE_BIT = 6;
   localparam int IRQ_PG_TIMEOUT_BIT = 3;
   localparam int IRQ_UV_WARN_BIT = 4;
   localparam int IRQ_UV_FAULT_BIT = 5;
   localparam int IRQ_TEMP_WARN_BIT = 6;
   localparam int IRQ_TEMP_FAULT_BIT = 7;
   localparam logic [7:0] KEEP_ALIVE_RAILS = 8'h2E;
   localparam logic [7:0] IRQ_FAULT_BITS = 8'hA8;

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] ENCTL_RESET = 8'h00;
   localparam logic [7:0] SYSTEM_CONTROL_TWO_RESET = 8'h01;
   localparam logic [7:0] TGT_FLAGS_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET = 8'h00;

   // Sequencer states.
   typedef enum logic [1:0] {
      PSFM_STARTUP = 2'b00,
      PSFM_RUN = 2'b01,
      PSFM_INHIBIT = 2'b10
   } psfm_state_e;

endpackage

// file: psfm_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the inputs are asynchronous to core_clk_in.
`timescale 1ns/10ps
module psfm_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] agree;

   // Only the second stage reads the first; the output moves per bit
   // once stages two and three agree, which rejects one-cycle slivers.
   assign agree = ~(s2_q ^ s3_q);

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         q_out <= RST;
      end else begin
         s1_q <= d_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_out <= (agree & s3_q) | (~agree & q_out);
      end
   end

endmodule // psfm_sync

// file: psfm_persist.sv
// Persistence timer: reports a condition once it has held COUNT cycles.
// Assumes a synchronous condition on core_clk_in.
`timescale 1ns/10ps
module psfm_persist #(
   parameter int COUNT = 2
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Condition and result
   input wire logic cond_in,
   output logic done_out
);

   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic at_last;

   // Any drop of the condition restarts the count from zero.
   assign at_last = (cnt_q == LAST);
   assign cnt_d = !cond_in ? '0 : (at_last ? cnt_q : cnt_q + 1'b1);
   assign done_out = cond_in & at_last;

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule // psfm_persist

// file: psfm_checker.sv
// Concurrent checks on the ports of psfm_top, attached by bind.
// Assumes the short counts that the bench hands to the design.
`timescale 1ns/10ps
module psfm_checker #(
   parameter int EN_DELAY = 20,
   parameter int TIMER = 400
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Watched inputs
   input wire logic [7:0] rail_enable_pin_in,
   input wire logic power_on_request_in,
   // Watched outputs
   input wire logic [7:0] rail_enable_out,
   input wire logic reset_output_n_out,
   input wire logic interrupt_n_out,
   input wire logic wake_pull_low_out,
   input wire logic [7:0] regulator_enable_control_out,
   input wire logic [7:0] system_control_two_out,
   input wire logic [7:0] interrupt_status_out
);
   int unsigned up_q;
   int unsigned pin_q;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   // Cycles since reset, and how long rail 2's pin has been high.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         up_q <= 0;
         pin_q <= 0;
      end else begin
         up_q <= (up_q < TIMER) ? up_q + 1 : up_q;
         pin_q <= rail_enable_pin_in[2] ? pin_q + 1 : 0;
      end
   end

   irq_pin_a: assert property (
      interrupt_n_out == !(|interrupt_status_out))
      else $error("interrupt pin disagrees with status");
   fault_enctl_a: assert property (
      $rose(wake_pull_low_out) |-> regulator_enable_control_out == 8'h00)
      else $error("enable control kept on shutdown");
   fault_scr_a: assert property (
      $rose(wake_pull_low_out) |-> system_control_two_out == 8'h01)
      else $error("system control two kept on shutdown");
   inhibit_off_a: assert property (
      wake_pull_low_out ##1 wake_pull_low_out |-> rail_enable_out[7:1] == 7'h00)
      else $error("rail enabled during inhibit");
   fault_keep_a: assert property (
      wake_pull_low_out && interrupt_status_out[7] |=> interrupt_status_out[7])
      else $error("fault status lost during inhibit");
   startup_rst_a: assert property (
      up_q < TIMER |-> !reset_output_n_out)
      else $error("reset output released early");
   pin_delay_a: assert property (
      $rose(rail_enable_out[2]) && !regulator_enable_control_out[7]
         |-> pin_q >= EN_DELAY)
      else $error("rail enabled before pin delay");
   shutdown_clr_a: assert property (
      power_on_request_in ##1 !power_on_request_in [*8]
         |-> regulator_enable_control_out == 8'h00)
      else $error("enable control not cleared on shutdown");
   temp_idle_a: assert property (
      (rail_enable_out[7:1] == 7'h00) [*8] |=> !$rose(interrupt_status_out[6]))
      else $error("thermal warning raised with rails off");
endmodule // psfm_checker

bind psfm_top psfm_checker #(.EN_DELAY(EN_DELAY), .TIMER(TIMER)) chk_u (
   .core_clk_in, .reset_n_in, .rail_enable_pin_in, .power_on_request_in,
   .rail_enable_out, .reset_output_n_out, .interrupt_n_out,
   .wake_pull_low_out, .regulator_enable_control_out,
   .system_control_two_out, .interrupt_status_out);

// file: psfm_rails.sv
// Behavioural model of the eight regulator outputs.
// Assumes enables come from psfm_top on the same clock.
`timescale 1ns/10ps
module psfm_rails (
   // Clock
   input wire logic core_clk_in,
   // Enables in, comparator levels out
   input wire logic [7:0] rail_enable_in,
   output logic [7:0] rail_good_out,
   output logic [7:0] rail_discharged_out
);
   logic [31:0] ramp_q = '0;

   // A rail ramps for four cycles; it reads discharged only once its
   // enable and its ramp are both gone, so a quick re-enable must wait.
   always_ff @(posedge core_clk_in) begin
      ramp_q <= {ramp_q[23:0], rail_enable_in};
   end
   assign rail_good_out = ramp_q[31:24] & rail_enable_in;
   assign rail_discharged_out = ~(ramp_q[31:24] | rail_enable_in);
endmodule // psfm_rails

// file: power_sequence_fault_monitor_bench.sv
// Self-checking bench for psfm_top with a behavioural rail model.
// Assumes the short counts set below; pins change 1 ns after an edge.
`timescale 1ns/10ps
module power_sequence_fault_monitor_bench;
   import psfm_pkg::*;
   localparam int ED = 20;
   localparam int TM = 400;
   localparam int LL = 200;
   logic core_clk_in = '0, reset_n_in = '0, power_on_request_in = '1;
   logic supply_warn_in = '0, supply_fault_in = '0, supply_lockout_in = '0;
   logic temp_warn_in = '0, temp_fault_in = '0, hard_reset_in = '0;
   logic enable_control_wr_in = '0, system_control_two_wr_in = '0;
   logic target_wr_in = '0, clear_irq_in = '0;
   logic [2:0] target_sel_in = '0;
   logic [7:0] rail_enable_pin_in = '0, rail_slewing_in = '0, wdata_in = '0;
   logic [7:0] rail_good_in, rail_discharged_in, rail_enable_out;
   logic [7:0] regulator_enable_control_out, system_control_two_out;
   logic [7:0] power_good_status_out, interrupt_status_out;
   logic power_good_pin_out, reset_output_n_out, interrupt_n_out;
   logic wake_pull_low_out;
   int failures = 0, n_compared = 0;
   // Rows: write to system control two, data, expected rail enables.
   logic [16:0] rows [6] = '{{1'b1, 8'h80, 8'h01}, {1'b0, 8'h81, 8'h03},
      {1'b0, 8'hFF, 8'hFF}, {1'b0, 8'h80, 8'h01}, {1'b1, 8'h01, 8'h01},
      {1'b0, 8'h00, 8'h01}};

   psfm_top #(.EN_DELAY(ED), .SETTLE(30), .LONG_LOW(LL), .TIMER(TM)) dut_u (.*);
   psfm_rails rails_u (.core_clk_in(core_clk_in),
      .rail_enable_in(rail_enable_out), .rail_good_out(rail_good_in),
      .rail_discharged_out(rail_discharged_in));

   // Free-running 100 MHz clock.
   initial begin
      forever #5 core_clk_in = ~core_clk_in;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle register write strobe, to either register.
   task automatic wr(input logic two, input logic [7:0] d);
      wdata_in = d;
      enable_control_wr_in = !two;
      system_control_two_wr_in = two;
      tick(1);
      enable_control_wr_in = 1'b0;
      system_control_two_wr_in = 1'b0;
   endtask

   task automatic clr;
      clear_irq_in = 1'b1;
      tick(1);
      clear_irq_in = 1'b0;
      tick(1);
   endtask

   task automatic give_verdict;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // A hang is cut short well after the sequence should have ended.
   initial begin
      #100us;
      failures++;
      give_verdict();
   end

   // Main sequence: reset, register rows, then the awkward cases.
   initial begin
      tick(16);
      reset_n_in = 1'b1;
      tick(1);
      cmp(regulator_enable_control_out, 8'h00);
      cmp(system_control_two_out, 8'h01);
      cmp({7'h00, reset_output_n_out}, 8'h00);
      tick(TM + 20);
      cmp({7'h00, reset_output_n_out}, 8'h01);
      $display("reset test done");
      foreach (rows[i]) begin
         wr(rows[i][16], rows[i][15:8]);
         cmp(rows[i][16] ? system_control_two_out
            : regulator_enable_control_out, rows[i][15:8]);
         tick(12);
         cmp(rail_enable_out, rows[i][7:0]);
      end
      $display("register rows done");
      rail_enable_pin_in = 8'h04;
      tick(ED);
      cmp(rail_enable_out, 8'h01);
      tick(10);
      cmp(rail_enable_out, 8'h05);
      tick(50);
      cmp({7'h00, power_good_pin_out}, 8'h01);
      cmp(power_good_status_out, 8'h05);
      wr(1'b0, 8'h83);
      power_on_request_in = 1'b0;
      tick(8);
      cmp(regulator_enable_control_out, 8'h00);
      power_on_request_in = 1'b1;
      tick(40);
      $display("pin and shutdown tests done");
      for (int k = 0; k < 2; k++) begin
         {temp_warn_in, supply_warn_in} = k ? 2'b10 : 2'b01;
         tick(8);
         cmp(interrupt_status_out, k ? 8'h40 : 8'h10);
         clr();
         cmp(interrupt_status_out, k ? 8'h40 : 8'h10);
         {temp_warn_in, supply_warn_in} = 2'b00;
         tick(8);
         clr();
         cmp(interrupt_status_out, 8'h00);
      end
      $display("warning tests done");
      temp_fault_in = 1'b1;
      tick(8);
      cmp(interrupt_status_out, 8'h80);
      cmp({7'h00, wake_pull_low_out}, 8'h01);
      cmp(rail_enable_out, 8'h01);
      clr();
      cmp(interrupt_status_out, 8'h80);
      temp_fault_in = 1'b0;
      tick(TM + 20);
      cmp({7'h00, wake_pull_low_out}, 8'h00);
      clr();
      cmp(interrupt_status_out, 8'h00);
      target_sel_in = 3'h1;
      target_wr_in = 1'b1;
      wdata_in = 8'h40;
      tick(1);
      target_wr_in = 1'b0;
      tick(12);
      cmp(rail_enable_out, 8'h07);
      hard_reset_in = 1'b1;
      tick(1);
      hard_reset_in = 1'b0;
      tick(4);
      cmp({7'h00, reset_output_n_out}, 8'h00);
      tick(TM + LL + 40);
      cmp({7'h00, reset_output_n_out}, 8'h01);
      cmp(rail_enable_out, 8'h05);
      $display("fault tests done");
      give_verdict();
   end
endmodule // power_sequence_fault_monitor_bench
